// ### core/vpdc_pkg.sv
`default_nettype none
package vpdc_pkg;
  // power_mode_select_reg fields
  localparam int unsigned SLEEP_SEL_BIT = 7;
  localparam int unsigned INT_DIV_BIT = 6;
  localparam int unsigned BUS_ISO_BIT = 5;
  // refresh_interval_reg fields
  localparam int unsigned GEN_SEL_BIT = 7;
  localparam int unsigned INTERVAL_MSB = 6;
  // refresh_per_line_reg encodings
  localparam logic [1:0] RPL_ONE = 2'h1;
  localparam logic [1:0] RPL_TWO = 2'h3;
  localparam logic [7:0] MODE_SEL_RST = 8'h00;
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic [1:0] RPL_RST = 2'h1;
  // clock divide while slowed, and character time in power-down clocks
  localparam int unsigned DIV_FACTOR = 8;
  localparam logic [2:0] DIV_LAST = 3'h7;
  localparam logic [2:0] CHAR_LAST = 3'h7;
  localparam logic [7:0] INTERVAL_BIAS = 8'h05;
  localparam logic [7:0] CBR_RST = 8'h00;
  // command port offsets (word addresses)
  localparam logic [1:0] ADDR_MODE = 2'h0;
  localparam logic [1:0] ADDR_INTERVAL = 2'h1;
  localparam logic [1:0] ADDR_RPL = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam logic [31:0] UNMAPPED_READ = 32'h0;

  typedef enum logic [2:0] {
    VPDC_NORMAL = 3'b000,
    VPDC_IDLE = 3'b001,
    VPDC_GEN_EXT = 3'b011,
    VPDC_GEN_INT = 3'b010,
    VPDC_SLEEP = 3'b110,
    VPDC_ISOLATE = 3'b100
  } vpdc_state_e;
endpackage
`default_nettype wire

// ### core/vpdc_if.sv
`default_nettype none
interface vpdc_if;
  logic power_down_request_n;
  logic [7:0] power_mode_select_reg;
  logic [7:0] refresh_interval_reg;
  logic [1:0] refresh_per_line_reg;

  modport device (
    input power_down_request_n,
    input power_mode_select_reg,
    input refresh_interval_reg,
    input refresh_per_line_reg
  );
  modport manager (
    output power_down_request_n,
    output power_mode_select_reg,
    output refresh_interval_reg,
    output refresh_per_line_reg
  );
endinterface
`default_nettype wire

// ### core/vpdc_device.sv
`default_nettype none
module vpdc_device (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  vpdc_if.device link,
  input wire logic cbr_refresh_trigger_in,
  input wire logic crt_mode_in,
  output logic video_clk_en_out,
  output logic mem_clk_en_out,
  output logic dac_on_out,
  output logic panel_on_out,
  output logic display_on_out,
  output logic fetch_en_out,
  output logic arbitration_en_out,
  output logic cbr_refresh_cycle_out,
  output logic use_interval_timing_out,
  output logic host_io_allow_out,
  output logic host_mem_allow_out,
  output logic host_oe_allow_out,
  output logic [2:0] mode_out
);
  // ==========================================
  // synchroniser
  logic req_meta_r;
  logic req_sync_r;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      req_meta_r <= 1'b1;
      req_sync_r <= 1'b1;
    end else begin
      req_meta_r <= link.power_down_request_n;
      req_sync_r <= req_meta_r;
    end
  end

  // ==========================================
  // state decoding shared by the timers and the outputs
  function automatic logic is_slowed(input vpdc_pkg::vpdc_state_e s);
    return (s == vpdc_pkg::VPDC_IDLE) || (s == vpdc_pkg::VPDC_GEN_INT);
  endfunction

  function automatic logic is_general(input vpdc_pkg::vpdc_state_e s);
    return (s == vpdc_pkg::VPDC_GEN_EXT) || (s == vpdc_pkg::VPDC_GEN_INT);
  endfunction

  // sleep and isolation both cut the host off
  function automatic logic host_cut_off(input vpdc_pkg::vpdc_state_e s);
    return (s == vpdc_pkg::VPDC_ISOLATE) || (s == vpdc_pkg::VPDC_SLEEP);
  endfunction

  // idle and sleep refresh off the external trigger, with no arbitration
  function automatic logic trigger_refresh(input vpdc_pkg::vpdc_state_e s);
    return (s == vpdc_pkg::VPDC_IDLE) || (s == vpdc_pkg::VPDC_SLEEP);
  endfunction

  // one pulse in eight while the internal clocks are slowed
  function automatic logic div_pulse(input logic [2:0] cnt);
    return cnt == vpdc_pkg::DIV_LAST;
  endfunction

  // ==========================================
  // mode selection
  vpdc_pkg::vpdc_state_e state_r, state_nxt;
  logic [7:0] psel;
  logic [7:0] ival;
  assign psel = link.power_mode_select_reg;
  assign ival = link.refresh_interval_reg;

  always_comb begin
    state_nxt = vpdc_pkg::VPDC_NORMAL;
    if (!req_sync_r) begin
      if (psel[vpdc_pkg::BUS_ISO_BIT]) begin
        state_nxt = vpdc_pkg::VPDC_ISOLATE;
      end else if (psel[vpdc_pkg::SLEEP_SEL_BIT]) begin
        state_nxt = vpdc_pkg::VPDC_SLEEP;
      end else if (!ival[vpdc_pkg::GEN_SEL_BIT]) begin
        state_nxt = vpdc_pkg::VPDC_IDLE;
      end else if (psel[vpdc_pkg::INT_DIV_BIT]) begin
        state_nxt = vpdc_pkg::VPDC_GEN_INT;
      end else begin
        state_nxt = vpdc_pkg::VPDC_GEN_EXT;
      end
    end
  end

  // mode latches while the request stays low; selection bits changing mid-mode are ignored
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_r <= vpdc_pkg::VPDC_NORMAL;
    end else if (req_sync_r || state_r == vpdc_pkg::VPDC_NORMAL) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // divide-by-eight enable
  logic [2:0] div_cnt_r;
  logic slow;
  assign slow = is_slowed(state_r);
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !slow) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  // ==========================================
  // interval refresh timer for the general modes
  logic gen;
  logic [2:0] char_cnt_r;
  logic [7:0] ref_cnt_r;
  logic [7:0] ref_target;
  logic ref_tick;
  assign gen = is_general(state_r);
  // interval field holds count minus five; add it back to get characters between refreshes
  assign ref_target = {1'b0, ival[vpdc_pkg::INTERVAL_MSB:0]} + vpdc_pkg::INTERVAL_BIAS;
  // in internal mode one power-down clock is eight input clocks
  logic pd_clk_en;
  assign pd_clk_en = (state_r == vpdc_pkg::VPDC_GEN_EXT) || div_pulse(div_cnt_r);
  assign ref_tick = gen && pd_clk_en && (char_cnt_r == vpdc_pkg::CHAR_LAST) &&
                    (ref_cnt_r >= ref_target - 8'h01);
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !gen) begin
      char_cnt_r <= 3'h0;
    end else if (pd_clk_en) begin
      char_cnt_r <= char_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !gen || ref_tick) begin
      ref_cnt_r <= vpdc_pkg::CBR_RST;
    end else if (pd_clk_en && char_cnt_r == vpdc_pkg::CHAR_LAST) begin
      ref_cnt_r <= ref_cnt_r + 8'h01;
    end
  end

  // ==========================================
  // registered outputs, one block per concern
  logic idle;
  logic low_power;
  assign idle = state_r == vpdc_pkg::VPDC_IDLE;
  assign low_power = state_r != vpdc_pkg::VPDC_NORMAL;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      video_clk_en_out <= 1'b1;
      mem_clk_en_out <= 1'b1;
    end else begin
      video_clk_en_out <= !slow || div_pulse(div_cnt_r);
      mem_clk_en_out <= !slow || div_pulse(div_cnt_r);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dac_on_out <= 1'b0;
      panel_on_out <= 1'b0;
      display_on_out <= 1'b1;
      fetch_en_out <= 1'b1;
    end else begin
      dac_on_out <= !low_power && crt_mode_in;
      panel_on_out <= !low_power && !crt_mode_in;
      display_on_out <= !low_power;
      fetch_en_out <= !low_power;
    end
  end

  // general modes refresh off the interval timer instead of the trigger
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cbr_refresh_cycle_out <= 1'b0;
      use_interval_timing_out <= 1'b0;
    end else begin
      cbr_refresh_cycle_out <= (trigger_refresh(state_r) && cbr_refresh_trigger_in) || ref_tick;
      use_interval_timing_out <= gen;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      arbitration_en_out <= 1'b1;
      host_io_allow_out <= 1'b1;
      host_mem_allow_out <= 1'b1;
      host_oe_allow_out <= 1'b1;
      mode_out <= vpdc_pkg::VPDC_NORMAL;
    end else begin
      arbitration_en_out <= !trigger_refresh(state_r);
      host_io_allow_out <= !host_cut_off(state_r);
      host_mem_allow_out <= !idle && !host_cut_off(state_r);
      host_oe_allow_out <= state_r != vpdc_pkg::VPDC_ISOLATE;
      mode_out <= state_r;
    end
  end
endmodule
`default_nettype wire

// ### core/vpdc_manager.sv
`default_nettype none
module vpdc_manager (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  vpdc_if.manager link,
  // avalon-mm slave
  input wire logic [1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic clocks_stable_in
);
  // ==========================================
  // control registers; bit 0 of the status word requests power-down
  logic [7:0] mode_r;
  logic [7:0] interval_r;
  logic [1:0] rpl_r;
  logic pd_req_r;
  logic ack_r;
  logic access;
  assign access = (avs_read_in || avs_write_in) && !ack_r;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end
  // one wait state: answer the cycle after the request appears
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !access;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mode_r <= vpdc_pkg::MODE_SEL_RST;
      interval_r <= vpdc_pkg::INTERVAL_RST;
      rpl_r <= vpdc_pkg::RPL_RST;
      pd_req_r <= 1'b0;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      // a write lands on the edge that sees waitrequest low
      case (avs_address_in)
        vpdc_pkg::ADDR_MODE: mode_r <= avs_writedata_in[7:0];
        vpdc_pkg::ADDR_INTERVAL: interval_r <= avs_writedata_in[7:0];
        vpdc_pkg::ADDR_RPL: rpl_r <= avs_writedata_in[1:0];
        vpdc_pkg::ADDR_STATUS: pd_req_r <= avs_writedata_in[0];
        default: pd_req_r <= pd_req_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      avs_readdata_out <= vpdc_pkg::UNMAPPED_READ;
    end else if (access && avs_read_in) begin
      case (avs_address_in)
        vpdc_pkg::ADDR_MODE: avs_readdata_out <= {24'h0, mode_r};
        vpdc_pkg::ADDR_INTERVAL: avs_readdata_out <= {24'h0, interval_r};
        vpdc_pkg::ADDR_RPL: avs_readdata_out <= {30'h0, rpl_r};
        vpdc_pkg::ADDR_STATUS: avs_readdata_out <= {29'h0, clocks_stable_in, link.power_down_request_n, pd_req_r};
        default: avs_readdata_out <= vpdc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================
  // request pin: release only once clocks are stable
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      link.power_down_request_n <= 1'b1;
    end else if (pd_req_r) begin
      link.power_down_request_n <= 1'b0;
    end else if (clocks_stable_in) begin
      link.power_down_request_n <= 1'b1;
    end
  end
  assign link.power_mode_select_reg = mode_r;
  assign link.refresh_interval_reg = interval_r;
  assign link.refresh_per_line_reg = rpl_r;
endmodule
`default_nettype wire

// ### tb/vpdc_assertions.sv
`default_nettype none
module vpdc_assertions (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic power_down_request_n,
  input wire logic [7:0] power_mode_select_reg,
  input wire logic [7:0] refresh_interval_reg,
  input wire logic [2:0] mode_out,
  input wire logic mem_clk_en_out,
  input wire logic dac_on_out,
  input wire logic display_on_out,
  input wire logic fetch_en_out,
  input wire logic host_io_allow_out,
  input wire logic host_mem_allow_out,
  input wire logic host_oe_allow_out,
  input wire logic use_interval_timing_out
);
  // ==========================================================
  // mode entry, exit and per-mode outputs
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  idle_entry_a: assert property (
    $fell(power_down_request_n) && power_mode_select_reg[7:5] == 3'h0 && !refresh_interval_reg[7]
    |-> ##[3:4] mode_out == vpdc_pkg::VPDC_IDLE) else $error("idle mode not entered");
  gen_ext_a: assert property (
    $fell(power_down_request_n) && power_mode_select_reg[7:5] == 3'h0 && refresh_interval_reg[7]
    |-> ##[3:4] mode_out == vpdc_pkg::VPDC_GEN_EXT) else $error("external clock mode not entered");
  gen_int_a: assert property (
    $fell(power_down_request_n) && power_mode_select_reg[7:5] == 3'h2 && refresh_interval_reg[7]
    |-> ##[3:4] mode_out == vpdc_pkg::VPDC_GEN_INT) else $error("internal clock mode not entered");
  isolate_entry_a: assert property (
    $fell(power_down_request_n) && power_mode_select_reg[5]
    |-> ##[3:4] mode_out == vpdc_pkg::VPDC_ISOLATE && !host_oe_allow_out) else $error("bus not isolated");
  sync_delay_a: assert property (
    $fell(power_down_request_n) |=> $stable(mode_out) [*2]) else $error("request acted on too early");
  leave_mode_a: assert property (
    $rose(power_down_request_n) |-> ##[3:4] mode_out == vpdc_pkg::VPDC_NORMAL) else $error("mode not left");
  // the enable is the divided clock, so seven quiet cycles between pulses
  idle_div_a: assert property (
    mem_clk_en_out && mode_out == vpdc_pkg::VPDC_IDLE |=> (!mem_clk_en_out || mode_out != vpdc_pkg::VPDC_IDLE) [*7]
    ##1 (mem_clk_en_out || mode_out != vpdc_pkg::VPDC_IDLE)) else $error("idle clock not divided by eight");
  idle_outputs_a: assert property (
    mode_out == vpdc_pkg::VPDC_IDLE |-> !dac_on_out && !display_on_out && !fetch_en_out && host_io_allow_out
    && !host_mem_allow_out) else $error("idle outputs wrong");
  gen_outputs_a: assert property (
    mode_out inside {vpdc_pkg::VPDC_GEN_EXT, vpdc_pkg::VPDC_GEN_INT} |-> !dac_on_out && !display_on_out
    && host_io_allow_out && host_mem_allow_out && use_interval_timing_out) else $error("general mode outputs wrong");
endmodule
`default_nettype wire

// ### tb/tb_video_power_down_controller.sv
`default_nettype none
module tb_video_power_down_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] avs_address_in = 2'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic clocks_stable_in = 1'b1;
  logic cbr_refresh_trigger_in = 1'b0;
  logic crt_mode_in = 1'b1;
  logic video_clk_en_out, mem_clk_en_out, dac_on_out, panel_on_out, display_on_out, fetch_en_out;
  logic arbitration_en_out, cbr_refresh_cycle_out, use_interval_timing_out, host_io_allow_out;
  logic host_mem_allow_out, host_oe_allow_out;
  logic [2:0] mode_out;
  logic [31:0] q;
  int failures = 0;
  int n_checks = 0;
  int i, j, k;
  // ==========================================================
  // per mode: select reg, interval reg, mode, output mask, outputs
  logic [7:0] t_mode [5] = '{8'h00, 8'h00, 8'h40, 8'h80, 8'ha0};
  logic [7:0] t_int [5] = '{8'h00, 8'h82, 8'h80, 8'h00, 8'h80};
  logic [2:0] t_exp [5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  logic [7:0] t_msk [5] = '{8'hff, 8'ha7, 8'ha7, 8'h06, 8'h07};
  logic [7:0] t_out [5] = '{8'h05, 8'h07, 8'h07, 8'h00, 8'h00};
  always #5 ref_clk_in = ~ref_clk_in;
  vpdc_if link_if ();
  vpdc_manager vpdc_manager_inst (.ref_clk_in, .srst_in, .link(link_if), .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .clocks_stable_in);
  vpdc_device vpdc_device_inst (.ref_clk_in, .srst_in, .link(link_if), .cbr_refresh_trigger_in, .crt_mode_in,
    .video_clk_en_out, .mem_clk_en_out, .dac_on_out, .panel_on_out, .display_on_out, .fetch_en_out,
    .arbitration_en_out, .cbr_refresh_cycle_out, .use_interval_timing_out, .host_io_allow_out,
    .host_mem_allow_out, .host_oe_allow_out, .mode_out);
  vpdc_assertions vpdc_assertions_inst (.ref_clk_in, .srst_in, .mode_out, .mem_clk_en_out, .dac_on_out,
    .power_down_request_n(link_if.power_down_request_n), .display_on_out, .fetch_en_out, .host_io_allow_out,
    .power_mode_select_reg(link_if.power_mode_select_reg), .refresh_interval_reg(link_if.refresh_interval_reg),
    .host_mem_allow_out, .host_oe_allow_out, .use_interval_timing_out);
  // ==========================================================
  // bus tasks and checks
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    chk({31'h0, avs_waitrequest_out}, 32'h0);
    if (avs_waitrequest_out !== 1'b0) complete_run();
    @(posedge ref_clk_in);
  endtask
  task automatic wait_mode(input logic [2:0] e);
    for (k = 0; k < 30 && mode_out !== e; k++) @(posedge ref_clk_in);
    chk({29'h0, mode_out}, {29'h0, e});
    if (mode_out !== e) complete_run();
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    av(0, 2'h0, 0); chk(q, 32'h0);
    av(0, 2'h1, 0); chk(q, 32'h0);
    av(0, 2'h2, 0); chk(q, 32'h1);
    av(1, 2'h2, 32'h3);
    av(0, 2'h2, 0); chk(q, 32'h3);
    for (i = 0; i < 5; i++) begin
      av(1, 2'h0, {24'h0, t_mode[i]});
      av(1, 2'h1, {24'h0, t_int[i]});
      av(1, 2'h3, 32'h1);
      wait_mode(t_exp[i]);
      chk({24'h0, t_msk[i] & {dac_on_out, panel_on_out, display_on_out, fetch_en_out, arbitration_en_out,
        host_io_allow_out, host_mem_allow_out, host_oe_allow_out}}, {24'h0, t_out[i]});
      if (i == 0) begin
        j = 0;
        k = 0;
        cbr_refresh_trigger_in <= 1'b1;
        repeat (40) begin
          @(posedge ref_clk_in);
          if (cbr_refresh_cycle_out === 1'b1) j++;
          if (video_clk_en_out === 1'b1) k++;
        end
        cbr_refresh_trigger_in <= 1'b0;
        chk({31'h0, j != 0}, 32'h1);
        chk(k, 40 / vpdc_pkg::DIV_FACTOR);
      end
      if (i == 1) begin
        for (j = 0; j < 200 && cbr_refresh_cycle_out !== 1'b1; j++) @(posedge ref_clk_in);
        k = 0;
        do begin
          @(posedge ref_clk_in);
          k++;
        end while (cbr_refresh_cycle_out !== 1'b1 && k < 200);
        chk(k, (2 + 5) * 8);
      end
      // the pin must not rise until the clocks are reported stable
      clocks_stable_in <= 1'b0;
      av(1, 2'h3, 32'h0);
      repeat (10) @(posedge ref_clk_in);
      chk({29'h0, mode_out}, {29'h0, t_exp[i]});
      clocks_stable_in <= 1'b1;
      wait_mode(vpdc_pkg::VPDC_NORMAL);
    end
    complete_run();
  end
endmodule
`default_nettype wire
